// ===== ctl_pkg.sv
// Purpose: shared constants and types of the chroma timing logic
// Assumes: core clock of 100 MHz
// Notes: times are kept in ns, cycle counts derived from them
package ctl_pkg;

	// ------------------------------------------------------------
	// clock and time conversion
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;

	function automatic int cyc_up(input int ns);
		cyc_up = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (cyc_up < 1)
			cyc_up = 1;
	endfunction : cyc_up

	function automatic int cyc_down(input int ns);
		cyc_down = ns / CLK_PERIOD_NS;
		if (cyc_down < 1)
			cyc_down = 1;
	endfunction : cyc_down

	// ------------------------------------------------------------
	// line timing
	// ------------------------------------------------------------
	localparam int BG_DELAY_NS = 3600;
	localparam int BG_WIDTH_NS = 4400;
	localparam int HPULSE_NS = 4700;
	localparam int HOLDOFF_NS = 48000;
	localparam int BG_DELAY_CYC = cyc_up(BG_DELAY_NS);
	localparam int BG_WIDTH_CYC = cyc_down(BG_WIDTH_NS);
	localparam int HPULSE_CYC = cyc_down(HPULSE_NS);
	localparam int HOLDOFF_CYC = cyc_up(HOLDOFF_NS);
	localparam int TIMER_W = 16;

	// ------------------------------------------------------------
	// dividers
	// ------------------------------------------------------------
	localparam int DIV_NTSC = 320;
	localparam int DIV_OTHER = 321;
	localparam int LINE_CNT_W = 10;
	localparam int CARRIER_DIV = 8;
	localparam logic [2:0] QUARTER_STEP = 3'h2;
	localparam logic [2:0] HALF_STEP = 3'h4;
	localparam int REF_EDGES_LINE = 341;
	localparam int REF_TOL = 1;

	// ------------------------------------------------------------
	// standard select, three-level input as two bits
	// ------------------------------------------------------------
	localparam logic [1:0] STD_LVL_LOW = 2'h0;
	localparam logic [1:0] STD_LVL_MID = 2'h1;

	typedef enum logic [1:0] {CTL_NTSC, CTL_SECAM, CTL_PAL} ctl_std_t;

	function automatic ctl_std_t decode_std(input logic [1:0] lvl);
		if (lvl == STD_LVL_LOW)
			decode_std = CTL_NTSC;
		else if (lvl == STD_LVL_MID)
			decode_std = CTL_SECAM;
		else
			decode_std = CTL_PAL;
	endfunction : decode_std

endpackage : ctl_pkg

// ===== ctl_carrier_if.sv
// Purpose: link between the line timing and the carrier generator
// Assumes: single clock domain
// Notes: strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface ctl_carrier_if;
	import ctl_pkg::*;
	logic line_edge;
	logic id_pulse;
	logic playback;
	ctl_std_t std;
	logic carrier;
	modport src (output line_edge, output id_pulse, output playback, output std, input carrier);
	modport gen (input line_edge, input id_pulse, input playback, input std, output carrier);
endinterface : ctl_carrier_if
`default_nettype wire

// ===== ctl_carrier_gen.sv
// Purpose: divide-by-8 colour-under carrier with four-phase shifter
// Assumes: line_edge marks each rising edge of the line oscillator
// Notes: phase held as an offset of the eighth count, one quarter = 2
`timescale 1ns/10ps
`default_nettype none
module ctl_carrier_gen
	import ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ctl_carrier_if.gen cif
);
	logic [2:0] div_cnt;
	logic [2:0] phase;
	logic [2:0] next_phase;
	logic [2:0] sum;
	logic [2:0] id_step;

	// ------------------------------------------------------------
	// phase selection
	// ------------------------------------------------------------
	// id step per standard
	assign id_step = (cif.std == CTL_NTSC) ? HALF_STEP :
		(cif.std == CTL_PAL) ? QUARTER_STEP : 3'h0;
	assign next_phase = (cif.playback && cif.id_pulse) ? 3'(phase + id_step) : phase;
	// divide by 8, shifted 90 degrees
	assign sum = 3'(div_cnt + phase + QUARTER_STEP);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt <= 3'h0;
			phase <= 3'h0;
			cif.carrier <= 1'b0;
		end
		else
		begin
			if (cif.line_edge)
				div_cnt <= 3'(div_cnt + 3'h1);
			phase <= next_phase;
			cif.carrier <= sum[2];
		end
	end

	property p_phase_hold;
		@(posedge clk) disable iff (!rst_n)
		!(cif.playback && cif.id_pulse) |=> $stable(phase);
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase moved without id");

	property p_ntsc_invert;
		@(posedge clk) disable iff (!rst_n)
		(cif.playback && cif.id_pulse && cif.std == CTL_NTSC)
			|=> phase == 3'($past(phase) + HALF_STEP);
	endproperty
	a_ntsc_invert: assert property (p_ntsc_invert) else $error("ntsc id did not invert");

	property p_pal_quarter;
		@(posedge clk) disable iff (!rst_n)
		(cif.playback && cif.id_pulse && cif.std == CTL_PAL)
			|=> phase == 3'($past(phase) + QUARTER_STEP);
	endproperty
	a_pal_quarter: assert property (p_pal_quarter) else $error("pal id did not step 90");

endmodule : ctl_carrier_gen
`default_nettype wire

// ===== ctl_top.sv
// Purpose: line timing, dividers and pin logic of the chroma timing block
// Assumes: clk is the 100 MHz core clock; all inputs synchronous to it
// Notes: two-way pins are split into in/out/oe, oe high while driving
//
// Contract
// - divide line oscillator by 320 or 321
// - record mode drives AND of divider, line pulse
// - playback makes shared pin an ID input
// - carrier is line oscillator/8, shifted 90 degrees
// - each ID pulse in NTSC or PAL changes carrier phase, SECAM step is 0
// - NTSC inverts, PAL steps 90 degrees
// - burst gate low 3.6us after, 4.4us long
// - trim compare output floats while reference locked
// - subcarrier reference clocks all control logic; here all logic runs on clk, ref_osc_in is only sampled
// - playback AFC output prevents side lock
`timescale 1ns/10ps
`default_nettype none
module ctl_top
	import ctl_pkg::*;
#(
	parameter int HOLDOFF = HOLDOFF_CYC,
	parameter int REF_EDGES = REF_EDGES_LINE
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] std_level_in,
	input wire logic rec_mode,
	input wire logic comp_sync_n,
	input wire logic line_osc_in,
	input wire logic ref_osc_in,
	input wire logic tape_write_afc_pin_in,
	output logic tape_write_afc_pin_out,
	output logic tape_write_afc_pin_oe,
	output logic osc_trim_compare_out,
	output logic osc_trim_compare_oe,
	output logic burst_gate_n,
	output logic color_under_carrier_out,
	output logic playback_afc_out
);
	initial
	begin
		if (HOLDOFF < 1 || HOLDOFF >= (1 << TIMER_W) || REF_EDGES < 2 || REF_EDGES > 1000)
			$error("ctl_top: parameter out of range");
	end

	typedef enum logic [1:0] {BG_IDLE, BG_DELAY, BG_GATE} ctl_bg_t;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ------------------------------------------------------------
	// edges and decode
	// ------------------------------------------------------------
	logic sync_d, line_d, ref_d, id_d;
	logic sync_fall, line_edge, ref_edge, id_edge;
	ctl_std_t std;
	logic [LINE_CNT_W-1:0] div_n;
	assign std = decode_std(std_level_in);
	assign div_n = (std == CTL_NTSC) ? LINE_CNT_W'(DIV_NTSC) : LINE_CNT_W'(DIV_OTHER);
	assign sync_fall = sync_d && !comp_sync_n;
	assign line_edge = line_osc_in && !line_d;
	assign ref_edge = ref_osc_in && !ref_d;
	// id sampled only in playback
	// our own last record level must not pass for an id at the mode switch
	assign id_edge = !rec_mode && !tape_write_afc_pin_oe && tape_write_afc_pin_in && !id_d;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// low so a sync already low at release is no false line start
			sync_d <= 1'b0;
			line_d <= 1'b0;
			ref_d <= 1'b0;
			id_d <= 1'b0;
		end
		else
		begin
			sync_d <= comp_sync_n;
			line_d <= line_osc_in;
			ref_d <= ref_osc_in;
			id_d <= tape_write_afc_pin_in;
		end
	end

	// ------------------------------------------------------------
	// line pulse from composite sync
	// ------------------------------------------------------------
	logic [TIMER_W-1:0] holdoff_cnt;
	logic [TIMER_W-1:0] hp_cnt;
	logic h_start, h_level;
	assign h_start = sync_fall && (holdoff_cnt == '0);
	assign h_level = hp_cnt != '0;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			holdoff_cnt <= '0;
			hp_cnt <= '0;
		end
		else
		begin
			if (h_start)
				holdoff_cnt <= TIMER_W'(HOLDOFF);
			else if (holdoff_cnt != '0)
				holdoff_cnt <= holdoff_cnt - 1'b1;
			if (h_start)
				hp_cnt <= TIMER_W'(HPULSE_CYC);
			else if (h_level)
				hp_cnt <= hp_cnt - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// burst gate
	// ------------------------------------------------------------
	ctl_bg_t bg_state, next_bg_state;
	logic [TIMER_W-1:0] bg_cnt;
	logic bg_done;
	assign bg_done = bg_cnt == '0;

	always_comb
	begin
		next_bg_state = bg_state;
		case (bg_state)
			BG_IDLE:
				if (h_start)
					next_bg_state = BG_DELAY;
			BG_DELAY:
				if (bg_done)
					next_bg_state = BG_GATE;
			BG_GATE:
				if (bg_done)
					next_bg_state = BG_IDLE;
			default:
				next_bg_state = BG_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bg_state <= BG_IDLE;
			bg_cnt <= '0;
			burst_gate_n <= 1'b1;
		end
		else
		begin
			bg_state <= next_bg_state;
			if (bg_state == BG_IDLE && h_start)
				bg_cnt <= TIMER_W'(BG_DELAY_CYC - 1);
			else if (bg_state == BG_DELAY && bg_done)
				bg_cnt <= TIMER_W'(BG_WIDTH_CYC - 1);
			else if (!bg_done)
				bg_cnt <= bg_cnt - 1'b1;
			burst_gate_n <= next_bg_state != BG_GATE;
		end
	end

	// ------------------------------------------------------------
	// line-rate divider, record AFC, side lock guard
	// ------------------------------------------------------------
	logic [LINE_CNT_W-1:0] div_cnt;
	logic [LINE_CNT_W-1:0] line_edges;
	logic div_sq;
	assign div_sq = div_cnt < (div_n >> 1);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt <= '0;
			line_edges <= '0;
			tape_write_afc_pin_out <= 1'b0;
			tape_write_afc_pin_oe <= 1'b0;
			playback_afc_out <= 1'b0;
		end
		else
		begin
			if (line_edge)
				div_cnt <= (div_cnt >= div_n - 1'b1) ? '0 : div_cnt + 1'b1;
			if (h_start)
				line_edges <= '0;
			else if (line_edge && line_edges != '1)
				line_edges <= line_edges + 1'b1;
			// and of divider and line pulse
			tape_write_afc_pin_out <= rec_mode && div_sq && h_level;
			tape_write_afc_pin_oe <= rec_mode;
			// push oscillator up when short of edges
			if (rec_mode)
				playback_afc_out <= 1'b0;
			else if (h_start)
				playback_afc_out <= line_edges < div_n;
		end
	end

	// ------------------------------------------------------------
	// reference lock and trim comparison
	// ------------------------------------------------------------
	logic [LINE_CNT_W-1:0] ref_edges;
	logic ref_in_range, ref_locked;
	assign ref_in_range = (int'(ref_edges) >= REF_EDGES - REF_TOL) &&
		(int'(ref_edges) <= REF_EDGES + REF_TOL);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_edges <= '0;
			ref_locked <= 1'b0;
			osc_trim_compare_out <= 1'b0;
			osc_trim_compare_oe <= 1'b1;
		end
		else
		begin
			if (h_start)
				ref_edges <= '0;
			else if (ref_edge && ref_edges != '1)
				ref_edges <= ref_edges + 1'b1;
			if (h_start)
				ref_locked <= ref_in_range;
			osc_trim_compare_out <= ref_osc_in ^ div_sq;
			osc_trim_compare_oe <= !ref_locked;
		end
	end

	// ------------------------------------------------------------
	// colour-under carrier
	// ------------------------------------------------------------
	ctl_carrier_if cif ();
	assign cif.line_edge = line_edge;
	assign cif.id_pulse = id_edge;
	assign cif.playback = !rec_mode;
	assign cif.std = std;

	ctl_carrier_gen u_carrier (
		.clk(clk),
		.rst_n(rst_n),
		.cif(cif)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			color_under_carrier_out <= 1'b0;
		else
			color_under_carrier_out <= cif.carrier;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_div_wrap;
		@(posedge clk) disable iff (!rst_n)
		(line_edge && div_cnt == div_n - 1'b1) |=> div_cnt == '0;
	endproperty
	a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");

	property p_rec_and;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> tape_write_afc_pin_out == $past(rec_mode && div_sq && h_level);
	endproperty
	a_rec_and: assert property (p_rec_and) else $error("record afc not the and");

	property p_pb_release;
		@(posedge clk) disable iff (!rst_n)
		!rec_mode [*2] |-> !tape_write_afc_pin_oe && !tape_write_afc_pin_out;
	endproperty
	a_pb_release: assert property (p_pb_release) else $error("pin driven in playback");

	logic [TIMER_W-1:0] bg_age;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bg_age <= '0;
		else if (bg_state == BG_IDLE && h_start)
			bg_age <= TIMER_W'(1);
		else if (bg_age != '0 && bg_age <= TIMER_W'(BG_DELAY_CYC + BG_WIDTH_CYC))
			bg_age <= bg_age + 1'b1;
		else
			bg_age <= '0;
	end

	property p_bg_timing;
		@(posedge clk) disable iff (!rst_n)
		(bg_age != '0) |-> burst_gate_n == !(bg_age > TIMER_W'(BG_DELAY_CYC) &&
			bg_age <= TIMER_W'(BG_DELAY_CYC + BG_WIDTH_CYC));
	endproperty
	a_bg_timing: assert property (p_bg_timing) else $error("burst gate timing wrong");

	property p_trim_float;
		@(posedge clk) disable iff (!rst_n)
		ref_locked |=> !osc_trim_compare_oe;
	endproperty
	a_trim_float: assert property (p_trim_float) else $error("trim output driven while locked");

	property p_one_pulse;
		@(posedge clk) disable iff (!rst_n)
		h_start |=> !h_start [*8];
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("line pulse repeated");

	property p_side_lock;
		@(posedge clk) disable iff (!rst_n)
		(!rec_mode && h_start) |=> playback_afc_out == ($past(line_edges) < $past(div_n));
	endproperty
	a_side_lock: assert property (p_side_lock) else $error("playback afc wrong");

endmodule : ctl_top
`default_nettype wire

// ===== ctl_analog_model.sv
// Purpose: companion model with oscillators, sync and ID pulse source
// Assumes: a line of 1000 clk cycles, sync low for 30 of them
// Notes: a ref half period of zero stops the ref oscillator low; line osc toggles every osc_half cycles
`timescale 1ns/10ps
`default_nettype none
module ctl_analog_model
(
	input wire logic clk,
	input wire logic [3:0] osc_half,
	input wire logic [3:0] ref_half,
	input wire logic id_req,
	output logic comp_sync_n,
	output logic line_osc_in,
	output logic ref_osc_in,
	output logic id_out
);
	logic [9:0] lpos = 10'h000;
	logic [3:0] oc = 4'h0;
	logic [3:0] rc = 4'h0;
	logic [1:0] idc = 2'h0;

	initial
	begin
		comp_sync_n = 1'b1;
		line_osc_in = 1'b0;
		ref_osc_in = 1'b0;
		id_out = 1'b0;
	end

	// ------------------------------------------------------------
	// line timing and oscillators
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		lpos <= (lpos == 10'h3e7) ? 10'h000 : lpos + 10'h001;
		comp_sync_n <= (lpos >= 10'h01e);
		oc <= (oc + 4'h1 >= osc_half) ? 4'h0 : oc + 4'h1;
		if (oc + 4'h1 >= osc_half)
			line_osc_in <= !line_osc_in;
		rc <= (rc + 4'h1 >= ref_half) ? 4'h0 : rc + 4'h1;
		if (ref_half == 4'h0)
			ref_osc_in <= 1'b0;
		else if (rc + 4'h1 >= ref_half)
			ref_osc_in <= !ref_osc_in;
		idc <= id_req ? 2'h2 : (idc != 2'h0 ? idc - 2'h1 : 2'h0);
		id_out <= id_req || (idc > 2'h1);
	end
endmodule : ctl_analog_model
`default_nettype wire

// ===== ctl_top_tb.sv
// Purpose: self-checking bench of the chroma timing block
// Assumes: partner line of 1000 cycles; ref count matched to it
// Notes: holdoff shortened; both edges sampled, so delays gain one cycle
`timescale 1ns/10ps
`default_nettype none
module ctl_top_tb;
	import ctl_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] std_level_in = 2'h0;
	logic rec_mode = 1'b1;
	logic [3:0] osc_half = 4'h4;
	logic [3:0] ref_half = 4'h0;
	logic id_req = 1'b0;
	logic comp_sync_n, line_osc_in, ref_osc_in, id_out, pin, pin_out, pin_oe;
	logic trim, trim_oe, bg_n, car, pb_afc;
	logic lo_q = 1'b0, sy_q = 1'b1, bg_q = 1'b1, tr_q = 1'b0, car_q = 1'b0, arm = 1'b0;
	logic [31:0] seed = 32'h5d69_a296;
	int num_errors = 0;
	int comparisons = 0;
	int cyc = 0, ecnt = 0, t_sync = 0, t_bg = 0, t_trim = 0, m_car = 0, pin_bad = 0, pin_hi = 0;
	int q_bg[$], q_trim[$], q_car[$];

	assign pin = pin_oe ? pin_out : id_out;

	initial
		forever #5 clk = ~clk;

	ctl_analog_model u_ctl_analog_model (.clk(clk), .osc_half(osc_half), .ref_half(ref_half),
		.id_req(id_req), .comp_sync_n(comp_sync_n), .line_osc_in(line_osc_in),
		.ref_osc_in(ref_osc_in), .id_out(id_out));

	ctl_top #(.HOLDOFF(50), .REF_EDGES(125)) u_ctl_top (.clk(clk), .rstn(rstn),
		.std_level_in(std_level_in), .rec_mode(rec_mode), .comp_sync_n(comp_sync_n),
		.line_osc_in(line_osc_in), .ref_osc_in(ref_osc_in), .tape_write_afc_pin_in(pin),
		.tape_write_afc_pin_out(pin_out), .tape_write_afc_pin_oe(pin_oe),
		.osc_trim_compare_out(trim), .osc_trim_compare_oe(trim_oe), .burst_gate_n(bg_n),
		.color_under_carrier_out(car), .playback_afc_out(pb_afc));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction : xs

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		if (num_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task automatic drain;
		int n;
		n = 0;
		while (q_bg.size() + q_trim.size() + q_car.size() > 0 && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000)
		begin
			num_errors++;
			final_report();
		end
	endtask : drain

	// waits for a carrier rise, then sends an ID pulse at a random offset
	task automatic send_id(input logic [15:0] d);
		int n;
		logic p;
		p = 1'b1;
		n = 0;
		while (!(car && !p) && n < 200)
		begin
			p = car;
			@(posedge clk);
			n++;
		end
		if (n >= 200)
		begin
			num_errors++;
			final_report();
		end
		seed = xs(seed);
		// at least one edge, so the note never races the watcher
		repeat (int'(seed[3:0]) + 1) @(posedge clk);
		q_car.push_back(d);
		q_car.push_back(0);
		id_req <= 1'b1;
		@(posedge clk);
		id_req <= 1'b0;
		drain();
	endtask : send_id

	// ------------------------------------------------------------
	// output watcher
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		cyc++;
		if (line_osc_in && !lo_q)
			ecnt++;
		if (!comp_sync_n && sy_q)
			t_sync = cyc;
		if (!bg_n && bg_q && q_bg.size() > 0)
		begin
			t_bg = cyc;
			arm = 1'b1;
			chk(cyc - t_sync, q_bg.pop_front());
		end
		if (bg_n && !bg_q && arm && q_bg.size() > 0)
		begin
			arm = 1'b0;
			chk(cyc - t_bg, q_bg.pop_front());
		end
		if (trim && !tr_q)
		begin
			if (q_trim.size() > 0)
				chk(ecnt - t_trim, q_trim.pop_front());
			t_trim = ecnt;
		end
		if (car && !car_q)
		begin
			if (q_car.size() > 0)
				chk((ecnt - m_car) & 7, q_car.pop_front());
			m_car = ecnt;
		end
		if (pin_oe && pin_out)
		begin
			pin_hi++;
			if (cyc - t_sync > 475)
				pin_bad++;
		end
		lo_q = line_osc_in;
		sy_q = comp_sync_n;
		bg_q = bg_n;
		tr_q = trim;
		car_q = car;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		chk({bg_n, trim_oe, pin_out, pin_oe, trim, car, pb_afc}, 7'h60);
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 4; i++)
		begin
			std_level_in <= i[1:0];
			repeat (2600) @(posedge clk);
			q_trim.push_back(i == 0 ? DIV_NTSC : DIV_OTHER);
			q_trim.push_back(i == 0 ? DIV_NTSC : DIV_OTHER);
			q_car.push_back(0);
			drain();
		end
		q_bg = '{BG_DELAY_CYC + 1, BG_WIDTH_CYC, BG_DELAY_CYC + 1, BG_WIDTH_CYC};
		drain();
		chk(pin_bad, 1'h0);
		chk(pin_hi > 0, 1'h1);
		chk(pin_oe, 1'h1);
		chk(trim_oe, 1'h1);
		ref_half <= 4'h4;
		repeat (3000) @(posedge clk);
		chk(trim_oe, 1'h0);
		ref_half <= 4'h3;
		repeat (3000) @(posedge clk);
		chk(trim_oe, 1'h1);
		rec_mode <= 1'b0;
		repeat (3000) @(posedge clk);
		chk({pin_oe, pin_out}, 2'h0);
		chk(pb_afc, 1'h1);
		osc_half <= 4'h1;
		repeat (3000) @(posedge clk);
		chk(pb_afc, 1'h0);
		osc_half <= 4'h4;
		for (int k = 0; k < 3; k++)
		begin
			std_level_in <= k == 0 ? 2'h0 : (k == 1 ? 2'h2 : 2'h1);
			repeat (1000) @(posedge clk);
			q_car.push_back(0);
			drain();
			send_id(k == 0 ? 3'h4 : (k == 1 ? 3'h6 : 3'h0));
		end
		rec_mode <= 1'b1;
		repeat (3000) @(posedge clk);
		chk(pb_afc, 1'h0);
		final_report();
	end
endmodule : ctl_top_tb
`default_nettype wire
